// ==== rtl/lfbu_pkg.sv ====
// Constants, encodings and pixel type for the aperture write unpacker.
// Assumes one core clock shared by the host end and the device end.
package lfbu_pkg;

    // Link request kinds
    typedef enum logic [1:0] {
        LFBU_K_REGWR = 2'h0,
        LFBU_K_REGRD = 2'h1,
        LFBU_K_PIXEL = 2'h2
    } lfbu_kind_t;

    // Device register indices on the link
    localparam logic [7:0] LFBU_IDX_RBC     = 8'h00;
    localparam logic [7:0] LFBU_IDX_WMODE   = 8'h01;
    localparam logic [7:0] LFBU_IDX_CONSTANT_COLOR_ONE  = 8'h02;
    localparam logic [7:0] LFBU_IDX_ZACOLOR = 8'h03;
    localparam logic [7:0] LFBU_IDX_DISCARD = 8'h04;

    // host_write_mode_cfg fields
    localparam int LFBU_WM_FMT_LSB = 0;
    localparam int LFBU_WM_PIPE    = 8;
    localparam int LFBU_WM_ORD_LSB = 9;
    localparam int LFBU_WM_WSWAP   = 11;
    localparam int LFBU_WM_SWIZ    = 12;
    localparam int LFBU_WM_W       = 13;

    // Write format codes
    localparam logic [3:0] LFBU_FMT_RGB888   = 4'h4;
    localparam logic [3:0] LFBU_FMT_ARGB8888 = 4'h5;
    localparam logic [3:0] LFBU_FMT_Z565     = 4'hC;
    localparam logic [3:0] LFBU_FMT_Z555     = 4'hD;
    localparam logic [3:0] LFBU_FMT_Z1555    = 4'hE;
    localparam logic [3:0] LFBU_FMT_ZZ       = 4'hF;

    // render_buffer_control fields
    localparam int LFBU_RB_CLIP   = 0;
    localparam int LFBU_RB_CHROMA = 1;
    localparam int LFBU_RB_STIP   = 2;
    localparam int LFBU_RB_WSEL   = 3;
    localparam int LFBU_RB_ZEN    = 4;
    localparam int LFBU_RB_ZF_LSB = 5;
    localparam int LFBU_RB_DITH   = 8;
    localparam int LFBU_RB_RGBWE  = 9;
    localparam int LFBU_RB_ZAWE   = 10;
    localparam int LFBU_RB_DITH2  = 11;
    localparam int LFBU_RB_STPAT  = 12;
    localparam int LFBU_RB_AMASK  = 13;
    localparam int LFBU_RB_ZBIAS  = 16;
    localparam int LFBU_RB_W      = 17;
    localparam logic [16:0] LFBU_RB_WMASK = 17'h13FFF;

    // Constant depth-alpha register fields
    localparam int LFBU_ZA_A_LSB = 24;
    localparam int LFBU_ZA_Z_LSB = 0;

    // Reset values
    localparam logic [16:0] LFBU_RB_RST    = 17'h00000;
    localparam logic [12:0] LFBU_WM_RST    = 13'h0000;
    localparam logic [23:0] LFBU_C1_RST    = 24'h000000;
    localparam logic [31:0] LFBU_ZA_RST    = 32'h00000000;

    // Host controller AXI4-Lite offsets and fields
    localparam logic [3:0] LFBU_HOFF_DATA   = 4'h0;
    localparam logic [3:0] LFBU_HOFF_CTRL   = 4'h4;
    localparam logic [3:0] LFBU_HOFF_STATUS = 4'h8;
    localparam logic [3:0] LFBU_HOFF_RSP    = 4'hC;
    localparam int LFBU_CTRL_KIND_LSB = 8;
    localparam int LFBU_ST_BUSY       = 0;
    localparam int LFBU_ST_REFUSED    = 1;
    localparam logic [1:0] LFBU_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LFBU_RESP_SLVERR = 2'h2;

    // One unpacked pixel
    typedef struct packed {
        logic        ok;
        logic        has_rgb;
        logic        has_depth;
        logic        two;
        logic [7:0]  r;
        logic [7:0]  g;
        logic [7:0]  b;
        logic [7:0]  a;
        logic [15:0] d0;
        logic [15:0] d1;
    } lfbu_pix_t;

endpackage : lfbu_pkg

// ==== rtl/lfbu_if.sv ====
// Link between the host write end and the device unpacker end.
// Assumes both ends run on the same clock; no clocking block.
`timescale 1ns/1ps
interface lfbu_if;
    import lfbu_pkg::*;

    logic        req_valid;
    logic        req_ready;
    lfbu_kind_t  req_kind;
    logic [7:0]  req_addr;
    logic [31:0] req_data;
    logic        rsp_valid;
    logic [31:0] rsp_data;

    modport dev (
        input  req_valid,
        input  req_kind,
        input  req_addr,
        input  req_data,
        output req_ready,
        output rsp_valid,
        output rsp_data
    );

    modport host (
        output req_valid,
        output req_kind,
        output req_addr,
        output req_data,
        input  req_ready,
        input  rsp_valid,
        input  rsp_data
    );
endinterface : lfbu_if

// ==== rtl/lfbu_host.sv ====
// Host end: takes orders over AXI4-Lite and issues link requests.
// Assumes the device end shares aclk and answers reads on the link.
`timescale 1ns/1ps
module lfbu_host
    import lfbu_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Link
    lfbu_if.host             link
);

    typedef enum logic [2:0] {
        LFBU_H_IDLE = 3'b001,
        LFBU_H_REQ  = 3'b010,
        LFBU_H_WAIT = 3'b100
    } lfbu_hstate_t;

    typedef struct packed {
        lfbu_hstate_t st;
        logic         req_valid;
        lfbu_kind_t   kind;
        logic [7:0]   addr;
        logic [31:0]  data;
        logic [3:0]   fmt;
        logic         refused;
        logic [31:0]  rsp;
        logic [31:0]  cmd;
        logic         awready;
        logic         wready;
        logic         aw_got;
        logic         w_got;
        logic [3:0]   awaddr;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arready;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } lfbu_host_st_t;

    localparam lfbu_host_st_t LFBU_HOST_RST = '{
        st: LFBU_H_IDLE, kind: LFBU_K_REGWR, awready: 1'b1,
        wready: 1'b1, arready: 1'b1, default: '0};

    lfbu_host_st_t s_r;
    lfbu_host_st_t s_nxt;
    lfbu_kind_t    wkind;
    logic          fmt_bad;

    always_comb begin
        s_nxt = s_r;
        wkind = lfbu_kind_t'(s_r.wdata[LFBU_CTRL_KIND_LSB +: 2]);
        fmt_bad = !(s_r.fmt inside {LFBU_FMT_RGB888, LFBU_FMT_ARGB8888,
                    LFBU_FMT_Z565, LFBU_FMT_Z555, LFBU_FMT_Z1555,
                    LFBU_FMT_ZZ});
        case (s_r.st)
            LFBU_H_IDLE: ;
            LFBU_H_REQ: begin
                if (link.req_ready) begin
                    s_nxt.req_valid = 1'b0;
                    s_nxt.st = (s_r.kind == LFBU_K_REGRD) ?
                               LFBU_H_WAIT : LFBU_H_IDLE;
                end
            end
            LFBU_H_WAIT: begin
                if (link.rsp_valid) begin
                    s_nxt.rsp = link.rsp_data;
                    s_nxt.st = LFBU_H_IDLE;
                end
            end
            default: begin
                s_nxt.st = LFBU_H_IDLE;
                s_nxt.req_valid = 1'b0;
            end
        endcase
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = LFBU_RESP_OKAY;
            case (s_r.awaddr)
                LFBU_HOFF_DATA: begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_r.wstrb[i])
                            s_nxt.cmd[i*8 +: 8] = s_r.wdata[i*8 +: 8];
                    end
                end
                LFBU_HOFF_STATUS: begin
                    if (s_r.wdata[LFBU_ST_REFUSED])
                        s_nxt.refused = 1'b0;
                end
                LFBU_HOFF_CTRL: begin
                    if (s_r.st != LFBU_H_IDLE)
                        s_nxt.refused = 1'b1;
                    else if (wkind == LFBU_K_PIXEL && fmt_bad)
                        s_nxt.refused = 1'b1;
                    else if (!(wkind inside {LFBU_K_REGWR, LFBU_K_REGRD,
                                             LFBU_K_PIXEL}))
                        s_nxt.refused = 1'b1;
                    else begin
                        // One whole pixel per aligned word
                        s_nxt.kind = wkind;
                        s_nxt.addr = s_r.wdata[7:0];
                        s_nxt.data = s_r.cmd;
                        s_nxt.req_valid = 1'b1;
                        s_nxt.st = LFBU_H_REQ;
                        if (wkind == LFBU_K_REGWR &&
                            s_r.wdata[7:0] == LFBU_IDX_WMODE)
                            s_nxt.fmt = s_r.cmd[LFBU_WM_FMT_LSB +: 4];
                    end
                end
                LFBU_HOFF_RSP: ;
                default: s_nxt.bresp = LFBU_RESP_SLVERR;
            endcase
        end
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_got = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = LFBU_RESP_OKAY;
            case (s_axi_araddr)
                LFBU_HOFF_DATA:   s_nxt.rdata = s_r.cmd;
                LFBU_HOFF_CTRL:   s_nxt.rdata = 32'h0;
                LFBU_HOFF_STATUS: s_nxt.rdata = {30'h0,
                    s_r.refused, s_r.st != LFBU_H_IDLE};
                LFBU_HOFF_RSP:    s_nxt.rdata = s_r.rsp;
                default: begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = LFBU_RESP_SLVERR;
                end
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            s_r <= LFBU_HOST_RST;
        else
            s_r <= s_nxt;
    end

    assign s_axi_awready  = s_r.awready;
    assign s_axi_wready   = s_r.wready;
    assign s_axi_bvalid   = s_r.bvalid;
    assign s_axi_bresp    = s_r.bresp;
    assign s_axi_arready  = s_r.arready;
    assign s_axi_rvalid   = s_r.rvalid;
    assign s_axi_rdata    = s_r.rdata;
    assign s_axi_rresp    = s_r.rresp;
    assign link.req_valid = s_r.req_valid;
    assign link.req_kind  = s_r.kind;
    assign link.req_addr  = s_r.addr;
    assign link.req_data  = s_r.data;

endmodule : lfbu_host

// ==== rtl/lfbu_dev.sv ====
// Device end: unpacks aperture writes and holds render control.
// Assumes the host end shares aclk; pixel sink may stall on pix_ready.
//
// Functional notes
// - Format 3 is unsupported, no defined result.
// - Format 4 byte channels by order code.
// - Host sends one aligned pixel per word.
// - Format 4 alpha, depth from constants when piped.
// - Format 5 alpha and colour bytes by order.
// - Format 5 depth from constant when piped.
// - Formats 6 to 11 unsupported, host avoids them.
// - Format 12 colour 5-6-5 plus 16-bit depth.
// - Formats 12, 13 alpha from constant when piped.
// - Format 13 colour 5-5-5 by order code.
// - Host depth encoding matches active depth mode.
// - Format 14 one alpha bit replicated eight times.
// - Format 15 two depths, constant colour when piped.
// - Control bits 0-2: clip, chroma, stipple enables.
// - Bit 3 depth source, 4 enable, 7:5 function.
// - Bit 8 dither enable, bit 11 pattern select.
// - Bits 9, 10 clear suppress colour, depth writes.
// - Bits 12, 13, 16 enables; 15:14 reserved.
// - Mode bit 11 exchanges depth and colour halves.
// - Swizzle bytes first, then halves, then channels; formats 4 and 5 take channels without the half swap.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module lfbu_dev
    import lfbu_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Link
    lfbu_if.dev              link,
    // Pixel output
    output logic             pix_valid,
    input  wire logic        pix_ready,
    output logic [7:0]       pix_red,
    output logic [7:0]       pix_green,
    output logic [7:0]       pix_blue,
    output logic [7:0]       pix_alpha,
    output logic [15:0]      pix_depth0,
    output logic [15:0]      pix_depth1,
    output logic             pix_two_depth,
    output logic             pix_rgb_we,
    output logic             pix_za_we,
    output logic             pix_through_pipe,
    // Render control fields
    output logic             clip_en,
    output logic             chroma_en,
    output logic             stipple_en,
    output logic             wbuf_sel,
    output logic             depth_en,
    output logic [2:0]       depth_func,
    output logic             dither_en,
    output logic             dither_2x2,
    output logic             stipple_pattern,
    output logic             alpha_mask_en,
    output logic             depth_bias_en
);

    typedef struct packed {
        logic [16:0]  rbc;
        logic [12:0]  wmode;
        logic [23:0]  constant_color_one;
        logic [31:0]  za;
        logic [15:0]  discards;
        logic         ready;
        logic         rsp_valid;
        logic [31:0]  rsp_data;
        logic         pix_valid;
        lfbu_pix_t    pix;
        logic         rgb_we;
        logic         za_we;
        logic         thru;
    } lfbu_dev_st_t;

    localparam lfbu_dev_st_t LFBU_DEV_RST = '{
        rbc: LFBU_RB_RST, wmode: LFBU_WM_RST, constant_color_one: LFBU_C1_RST,
        za: LFBU_ZA_RST, default: '0};

    function automatic logic [7:0] lfbu_e5(input logic [4:0] x);
        return {x, x[4:2]};
    endfunction : lfbu_e5

    function automatic logic [7:0] lfbu_e6(input logic [5:0] x);
        return {x, x[5:4]};
    endfunction : lfbu_e6

    function automatic lfbu_pix_t lfbu_unpack(
        input logic [31:0] word,
        input logic [12:0] mode,
        input logic [23:0] c1,
        input logic [31:0] za
    );
        lfbu_pix_t   p;
        logic [31:0] sw;
        logic [31:0] hw;
        logic [15:0] c;
        logic [1:0]  ord;
        logic        pipe;
        logic [7:0]  hi8;
        logic [7:0]  mid8;
        logic [7:0]  lo8;
        logic [4:0]  hi5;
        logic [4:0]  g5;
        logic [4:0]  lo5;
        logic        abit;
        // Byte swizzle, then half swap for 16-bit formats, then channels
        sw = mode[LFBU_WM_SWIZ] ?
             {word[7:0], word[15:8], word[23:16], word[31:24]} : word;
        hw = mode[LFBU_WM_WSWAP] ? {sw[15:0], sw[31:16]} : sw;
        c = hw[15:0];
        ord = mode[LFBU_WM_ORD_LSB +: 2];
        pipe = mode[LFBU_WM_PIPE];
        // Byte channels shift up one byte for orders 2 and 3
        hi8 = ord[1] ? sw[31:24] : sw[23:16];
        mid8 = ord[1] ? sw[23:16] : sw[15:8];
        lo8 = ord[1] ? sw[15:8] : sw[7:0];
        // 5-5-5 field placement, alpha bit top or bottom
        hi5 = ord[1] ? c[15:11] : c[14:10];
        g5 = ord[1] ? c[10:6] : c[9:5];
        lo5 = ord[1] ? c[5:1] : c[4:0];
        abit = ord[1] ? c[0] : c[15];
        p = '0;
        p.ok = 1'b1;
        case (mode[LFBU_WM_FMT_LSB +: 4])
            LFBU_FMT_RGB888, LFBU_FMT_ARGB8888: begin
                p.r = ord[0] ? lo8 : hi8;
                p.g = mid8;
                p.b = ord[0] ? hi8 : lo8;
                p.has_rgb = 1'b1;
                p.has_depth = pipe;
                if (pipe)
                    p.d0 = za[LFBU_ZA_Z_LSB +: 16];
                if (mode[LFBU_WM_FMT_LSB +: 4] == LFBU_FMT_ARGB8888)
                    p.a = ord[1] ? sw[7:0] : sw[31:24];
                else if (pipe)
                    p.a = za[LFBU_ZA_A_LSB +: 8];
            end
            LFBU_FMT_Z565: begin
                p.r = lfbu_e5(ord[0] ? c[4:0] : c[15:11]);
                p.g = lfbu_e6(c[10:5]);
                p.b = lfbu_e5(ord[0] ? c[15:11] : c[4:0]);
                p.a = pipe ? za[LFBU_ZA_A_LSB +: 8] : 8'h00;
                p.d0 = hw[31:16];
                p.has_rgb = 1'b1;
                p.has_depth = 1'b1;
            end
            LFBU_FMT_Z555, LFBU_FMT_Z1555: begin
                p.r = lfbu_e5(ord[0] ? lo5 : hi5);
                p.g = lfbu_e5(g5);
                p.b = lfbu_e5(ord[0] ? hi5 : lo5);
                if (mode[LFBU_WM_FMT_LSB +: 4] == LFBU_FMT_Z1555)
                    p.a = {8{abit}};
                else if (pipe)
                    p.a = za[LFBU_ZA_A_LSB +: 8];
                p.d0 = hw[31:16];
                p.has_rgb = 1'b1;
                p.has_depth = 1'b1;
            end
            LFBU_FMT_ZZ: begin
                p.d0 = hw[15:0];
                p.d1 = hw[31:16];
                p.two = 1'b1;
                p.has_depth = 1'b1;
                p.has_rgb = pipe;
                if (pipe) begin
                    p.r = c1[23:16];
                    p.g = c1[15:8];
                    p.b = c1[7:0];
                    p.a = za[LFBU_ZA_A_LSB +: 8];
                end
            end
            default: p.ok = 1'b0;
        endcase
        return p;
    endfunction : lfbu_unpack

    lfbu_dev_st_t s_r;
    lfbu_dev_st_t s_nxt;
    lfbu_pix_t    up;

    always_comb begin
        s_nxt = s_r;
        up = lfbu_unpack(link.req_data, s_r.wmode, s_r.constant_color_one, s_r.za);
        s_nxt.rsp_valid = 1'b0;
        if (s_r.pix_valid && pix_ready)
            s_nxt.pix_valid = 1'b0;
        if (link.req_valid && s_r.ready) begin
            case (link.req_kind)
                LFBU_K_REGWR: begin
                    case (link.req_addr)
                        LFBU_IDX_RBC: s_nxt.rbc =
                            link.req_data[16:0] & LFBU_RB_WMASK;
                        LFBU_IDX_WMODE:
                            s_nxt.wmode = link.req_data[12:0];
                        LFBU_IDX_CONSTANT_COLOR_ONE:
                            s_nxt.constant_color_one = link.req_data[23:0];
                        LFBU_IDX_ZACOLOR:
                            s_nxt.za = link.req_data;
                        default: ;
                    endcase
                end
                LFBU_K_REGRD: begin
                    s_nxt.rsp_valid = 1'b1;
                    case (link.req_addr)
                        LFBU_IDX_RBC:
                            s_nxt.rsp_data = {15'h0, s_r.rbc};
                        LFBU_IDX_WMODE:
                            s_nxt.rsp_data = {19'h0, s_r.wmode};
                        LFBU_IDX_CONSTANT_COLOR_ONE:
                            s_nxt.rsp_data = {8'h00, s_r.constant_color_one};
                        LFBU_IDX_ZACOLOR:
                            s_nxt.rsp_data = s_r.za;
                        LFBU_IDX_DISCARD:
                            s_nxt.rsp_data = {16'h0000, s_r.discards};
                        default: s_nxt.rsp_data = 32'h00000000;
                    endcase
                end
                LFBU_K_PIXEL: begin
                    if (up.ok) begin
                        s_nxt.pix_valid = 1'b1;
                        s_nxt.pix = up;
                        s_nxt.rgb_we = up.has_rgb &&
                            s_r.rbc[LFBU_RB_RGBWE];
                        s_nxt.za_we = up.has_depth &&
                            s_r.rbc[LFBU_RB_ZAWE];
                        s_nxt.thru = s_r.wmode[LFBU_WM_PIPE];
                    end else begin
                        s_nxt.discards = s_r.discards + 16'h0001;
                    end
                end
                default: ;
            endcase
        end
        s_nxt.ready = !s_nxt.pix_valid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            s_r <= LFBU_DEV_RST;
        else
            s_r <= s_nxt;
    end

    assign link.req_ready   = s_r.ready;
    assign link.rsp_valid   = s_r.rsp_valid;
    assign link.rsp_data    = s_r.rsp_data;
    assign pix_valid        = s_r.pix_valid;
    assign pix_red          = s_r.pix.r;
    assign pix_green        = s_r.pix.g;
    assign pix_blue         = s_r.pix.b;
    assign pix_alpha        = s_r.pix.a;
    assign pix_depth0       = s_r.pix.d0;
    assign pix_depth1       = s_r.pix.d1;
    assign pix_two_depth    = s_r.pix.two;
    assign pix_rgb_we       = s_r.rgb_we;
    assign pix_za_we        = s_r.za_we;
    assign pix_through_pipe = s_r.thru;
    assign clip_en          = s_r.rbc[LFBU_RB_CLIP];
    assign chroma_en        = s_r.rbc[LFBU_RB_CHROMA];
    assign stipple_en       = s_r.rbc[LFBU_RB_STIP];
    assign wbuf_sel         = s_r.rbc[LFBU_RB_WSEL];
    assign depth_en         = s_r.rbc[LFBU_RB_ZEN];
    assign depth_func       = s_r.rbc[LFBU_RB_ZF_LSB +: 3];
    assign dither_en        = s_r.rbc[LFBU_RB_DITH];
    assign dither_2x2       = s_r.rbc[LFBU_RB_DITH2];
    assign stipple_pattern  = s_r.rbc[LFBU_RB_STPAT];
    assign alpha_mask_en    = s_r.rbc[LFBU_RB_AMASK];
    assign depth_bias_en    = s_r.rbc[LFBU_RB_ZBIAS];

endmodule : lfbu_dev

// ==== tb/lfbu_monitor.sv ====
// Link checker: request holding, read answers and pixel pacing.
// Assumes it sits beside the lfbu_if that joins both ends.
`timescale 1ns/1ps
module lfbu_monitor
    import lfbu_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Link
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire lfbu_kind_t  req_kind,
    input wire logic [7:0]  req_addr,
    input wire logic [31:0] req_data,
    input wire logic        rsp_valid,
    input wire logic [31:0] rsp_data
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire tk    = req_valid && req_ready;
    wire rd_tk = tk && req_kind == LFBU_K_REGRD;
    a_req_hold: assert property (req_valid && !req_ready |=>
        req_valid && $stable(req_data) && $stable(req_addr))
        else $error("link request changed while waiting");
    a_rd_answer: assert property (rd_tk |=> rsp_valid)
        else $error("read answer missing");
    a_rsp_cause: assert property (rsp_valid |-> $past(rd_tk))
        else $error("answer without read");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
    a_rsp_stable: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("read data moved without answer");
    a_rbc_reserved: assert property (rsp_valid &&
        $past(req_addr) == LFBU_IDX_RBC |->
        {rsp_data[31:17], rsp_data[15:14]} == 17'h0)
        else $error("reserved control bits read nonzero");
    a_wr_silent: assert property (tk && !rd_tk |=> !rsp_valid)
        else $error("answer after write");
    a_pix_gap: assert property (
        tk && req_kind == LFBU_K_PIXEL |=> !req_ready)
        else $error("ready while pixel held");
    cover property (rd_tk);
    cover property (tk && req_kind == LFBU_K_PIXEL);
    cover property (req_valid && !req_ready);
endmodule : lfbu_monitor

// ==== tb/lfb_write_unpack_render_ctrl_bench.sv ====
// Bench: host end and device end joined over the link, driven over AXI.
// Assumes the package, interface, both ends and the monitor come first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
$display("mismatch %s exp %h got %h", n, e, s); end end
module lfb_write_unpack_render_ctrl_bench;
    import lfbu_pkg::*;
    typedef struct packed {logic [12:0] m; logic [31:0] w; logic [47:0] e;}
        lfbu_row_t;
    lfbu_row_t rows [8] = '{
        '{13'h0104, 32'hFF112233, 48'h112233A50777},
        '{13'h0305, 32'h80332211, 48'h112233800777},
        '{13'h010C, 32'hBEEFF800, 48'hFF0000A5BEEF},
        '{13'h190C, 32'h3412E007, 48'h00FF00A51234},
        '{13'h050D, 32'h5555003E, 48'h0000FFA55555},
        '{13'h010E, 32'h22228000, 48'h000000FF2222},
        '{13'h070E, 32'h3333003E, 48'hFF0000003333},
        '{13'h010F, 32'hAAAA5555, 48'h123456A55555}};
    logic [3:0] bad [7] = '{4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
    logic aclk = 0, aresetn = 0, pix_ready = 0, awv = 0, wv = 0, arv = 0;
    logic [3:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, x;
    logic [1:0] rsp, wes;
    wire awr, wr, bv, arr, rv, pv;
    wire [31:0] rd;
    wire [1:0] rr, we;
    wire [47:0] p;
    wire [12:0] f;
    int n_errors = 0, checked = 0, cyc = 0;
    lfbu_if lnk ();
    lfbu_host u_lfbu_host (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_bresp(), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .link(lnk.host));
    lfbu_dev u_lfbu_dev (.aclk(aclk), .aresetn(aresetn), .link(lnk.dev),
        .pix_valid(pv), .pix_ready(pix_ready), .pix_red(p[47:40]),
        .pix_green(p[39:32]), .pix_blue(p[31:24]), .pix_alpha(p[23:16]),
        .pix_depth0(p[15:0]), .pix_depth1(), .pix_two_depth(),
        .pix_rgb_we(we[1]), .pix_za_we(we[0]), .pix_through_pipe(),
        .clip_en(f[0]), .chroma_en(f[1]), .stipple_en(f[2]), .wbuf_sel(f[3]),
        .depth_en(f[4]), .depth_func(f[7:5]), .dither_en(f[8]),
        .dither_2x2(f[9]), .stipple_pattern(f[10]), .alpha_mask_en(f[11]),
        .depth_bias_en(f[12]));
    lfbu_monitor u_lfbu_monitor (.aclk(aclk), .aresetn(aresetn),
        .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
        .req_kind(lnk.req_kind), .req_addr(lnk.req_addr),
        .req_data(lnk.req_data), .rsp_valid(lnk.rsp_valid),
        .rsp_data(lnk.rsp_data));
    initial forever #25 aclk = ~aclk;
    task automatic finish_test;
        if (n_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : finish_test
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            finish_test;
        end
    end
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (awv || wv);
        do @(posedge aclk); while (bv !== 1'b1);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        ara <= a;
        arv <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        d = rd;
        rsp = rr;
    endtask : axi_rd
    task automatic cmd(input logic [1:0] k, input logic [7:0] ix,
                       input logic [31:0] v);
        axi_wr(LFBU_HOFF_DATA, v);
        axi_wr(LFBU_HOFF_CTRL, {22'h0, k, ix});
        do axi_rd(LFBU_HOFF_STATUS, x); while (x[0] !== 1'b0);
    endtask : cmd
    task automatic pix(input logic [47:0] e);
        do @(posedge aclk); while (pv !== 1'b1);
        `CHK("pixel", e, p)
        wes = we;
        pix_ready <= 1'b1;
        @(posedge aclk);
        pix_ready <= 1'b0;
    endtask : pix
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        cmd(2'h0, LFBU_IDX_CONSTANT_COLOR_ONE, 32'h00123456);
        cmd(2'h0, LFBU_IDX_ZACOLOR, 32'hA5000777);
        cmd(2'h0, LFBU_IDX_RBC, 32'hFFFFFFFF);
        cmd(2'h1, LFBU_IDX_RBC, 32'h0);
        axi_rd(LFBU_HOFF_RSP, x);
        `CHK("control", 32'h00013FFF, x)
        `CHK("fields", 13'h1FFF, f)
        foreach (rows[i]) begin
            cmd(2'h0, LFBU_IDX_WMODE, {19'h0, rows[i].m});
            cmd(2'h2, 8'h00, rows[i].w);
            pix(rows[i].e);
        end
        axi_wr(LFBU_HOFF_DATA, 32'h00000400);
        axi_wr(LFBU_HOFF_CTRL, {24'h0, LFBU_IDX_RBC});
        cmd(2'h0, LFBU_IDX_WMODE, 32'h0000010C);
        cmd(2'h2, 8'h00, 32'h1234F800);
        pix(48'hFF0000A51234);
        `CHK("write enables", 2'b01, wes)
        foreach (bad[i]) begin
            cmd(2'h0, LFBU_IDX_WMODE, {28'h0, bad[i]});
            cmd(2'h2, 8'h00, 32'hFFFFFFFF);
            axi_rd(LFBU_HOFF_STATUS, x);
            `CHK("refused", 1'b1, x[1])
            axi_wr(LFBU_HOFF_STATUS, 32'h00000002);
        end
        `CHK("no pixel", 1'b0, pv)
        axi_rd(4'h2, x);
        `CHK("unmapped", LFBU_RESP_SLVERR, rsp)
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK("reset", 16'h0, {f, pv, we})
        finish_test;
    end
endmodule : lfb_write_unpack_render_ctrl_bench
